// ===== logic/cso_clock_supervisor.sv
/*
 Clock supervisor: clock output pin selection, clock-change lock and main oscillator stop/restart detector.
 Assumes i_f1_tick and i_sub_tick mark half periods of the peripheral base clock and sub clock,
 the stop level comes from an asynchronous analogue detector, and i_vmon0_reset is synchronous.
*/
`timescale 1ns/100ps
`default_nettype none

`include "cso_defs.svh"

// Notes on behaviour
// - Full-rate select 1 with field 00b outputs the peripheral base clock.
// - Full-rate select 0 with field 10b outputs base clock divided by 8.
// - Full-rate select 0 with field 11b outputs base clock divided by 32.
// - Full-rate select 0 with field 01b outputs the sub clock.
// - While the clock-change lock is set, writes to guarded clock controls are ignored.
// - With detection enabled, action 0 gives stop reset, action 1 gives interrupt.
// - Detection is only guaranteed for main oscillators running at 2 MHz or more.
// - In reset action a detected stop initialises state and then holds it stopped.
// - The held stop reset ends only by hardware reset or voltage monitor 0 reset.
// - Stop outside PLL mode: interrupt, slow oscillator on, on-chip select, flag, state set.
// - Stop in PLL mode: same, but the on-chip source select stays unchanged.
// - Restart: interrupt, slow oscillator on, select unchanged, flag set, state cleared.
// - In low-speed mode the CPU keeps the sub clock, peripherals take on-chip clock.
// - Whenever the on-chip source select is 1 the slow oscillator off bit reads 0.
// - The flag is set with the interrupt and blocks further ones until cleared.
// - The interrupt is non-maskable and shares its vector with the watchdog interrupt.
module cso_clock_supervisor
	import cso_pkg::*;
(
	// Clock and reset.
	input  wire logic         i_clk,
	input  wire logic         i_resetn,
	input  wire logic         i_vmon0_reset,
	// Register port.
	input  wire logic [2:0]   i_addr,
	input  wire logic [7:0]   i_wdata,
	input  wire logic         i_wr,
	input  wire logic         i_rd,
	output var  logic [7:0]   o_rdata,
	// Clock sources.
	input  wire logic         i_f1_tick,
	input  wire logic         i_sub_tick,
	input  wire logic         i_main_osc_stopped,
	input  wire logic         i_wdt_irq,
	// Clock control outputs.
	output var  cso_ctrl_t    o_ctrl,
	output var  logic [7:0]   o_pll_config_reg,
	output var  logic         o_clock_change_lock,
	output var  cso_clk_src_t o_cpu_src,
	output var  cso_clk_src_t o_periph_src,
	// Pin, interrupt and reset.
	output var  logic         o_clock_out_pin,
	output var  logic         o_nmi,
	output var  logic         o_stop_reset
);

	logic [1:0]     clock_out_pin_select_field;
	logic           clock_out_pin_full_rate_sel;
	logic           clock_reg_write_unlock;
	logic           power_reg_write_unlock;
	cso_det_state_t det_state;
	logic           stopped_s;
	logic           stopped_q;
	logic           tick_div8;
	logic           tick_div32;
	logic           sel_tick;
	logic           sel_valid;
	logic           stop_evt;
	logic           restart_evt;
	logic           irq_evt;
	logic           reset_evt;
	logic           soft_init;
	logic           pll_mode;
	logic           wr_ok;
	logic           wr_clk;
	logic           guard_ok;

	cso_tick_div #(
		.DIV      (`CSO_DIV8)
	) u_div8 (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_tick   (i_f1_tick),
		.o_tick   (tick_div8)
	);

	cso_tick_div #(
		.DIV      (`CSO_DIV32)
	) u_div32 (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_tick   (i_f1_tick),
		.o_tick   (tick_div32)
	);

	cso_sync #(
		.W        (1)
	) u_stop_sync (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_async  (i_main_osc_stopped),
		.o_sync   (stopped_s)
	);

	// Edge memory of the synchronised stop level.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			stopped_q <= 1'b0;
		end else begin
			stopped_q <= stopped_s;
		end
	end

	// Detection works on the synchronised level only; its bandwidth limit is that of the analogue detector.
	assign stop_evt    = o_ctrl.stop_detect_enable && stopped_s && !stopped_q;
	assign restart_evt = o_ctrl.stop_detect_enable && !stopped_s && stopped_q;
	assign reset_evt   = (det_state == CSO_DET_RUN) && !o_ctrl.stop_detect_action_sel
	                     && (stop_evt || restart_evt);
	assign irq_evt     = (det_state == CSO_DET_RUN) && o_ctrl.stop_detect_action_sel
	                     && (stop_evt || restart_evt) && !o_ctrl.stop_detect_flag;
	assign soft_init   = i_vmon0_reset || reset_evt;
	assign pll_mode    = o_ctrl.pll_cpu_select && !o_ctrl.onchip_source_select && !o_ctrl.sub_clock_cpu_select;
	assign wr_ok       = i_wr && (det_state == CSO_DET_RUN);
	assign wr_clk      = wr_ok && clock_reg_write_unlock;
	assign guard_ok    = !o_clock_change_lock;

	// Stop reset hold state.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			det_state    <= CSO_DET_RUN;
			o_stop_reset <= 1'b0;
		end else begin
			case (det_state)
				CSO_DET_RUN: begin
					if (reset_evt && !i_vmon0_reset) begin
						det_state    <= CSO_DET_HOLD;
						o_stop_reset <= 1'b1;
					end
				end
				CSO_DET_HOLD: begin
					if (i_vmon0_reset) begin
						det_state    <= CSO_DET_RUN;
						o_stop_reset <= 1'b0;
					end
				end
				default: begin
					det_state    <= CSO_DET_RUN;
					o_stop_reset <= 1'b0;
				end
			endcase
		end
	end

	// Write protection register.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			clock_reg_write_unlock <= 1'b0;
			power_reg_write_unlock <= 1'b0;
		end else if (soft_init) begin
			clock_reg_write_unlock <= 1'b0;
			power_reg_write_unlock <= 1'b0;
		end else if (wr_ok && i_addr == `CSO_ADDR_PROTECT) begin
			clock_reg_write_unlock <= i_wdata[`CSO_PR_CLK_UNLOCK];
			power_reg_write_unlock <= i_wdata[`CSO_PR_PWR_UNLOCK];
		end
	end

	// Clock-change lock, written only while the power register is unlocked.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_clock_change_lock <= 1'b0;
		end else if (soft_init) begin
			o_clock_change_lock <= 1'b0;
		end else if (wr_ok && power_reg_write_unlock && i_addr == `CSO_ADDR_POWER) begin
			o_clock_change_lock <= i_wdata[`CSO_PW_LOCK];
		end
	end

	// Clock control register file and detector effects.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_ctrl                      <= '0;
			o_ctrl.onchip_source_select <= `CSO_RST_ONCHIP;
			o_pll_config_reg            <= `CSO_RST_PLL;
			clock_out_pin_select_field         <= 2'h0;
			clock_out_pin_full_rate_sel        <= 1'b0;
		end else if (soft_init) begin
			o_ctrl                      <= '0;
			o_ctrl.onchip_source_select <= `CSO_RST_ONCHIP;
			o_pll_config_reg            <= `CSO_RST_PLL;
			clock_out_pin_select_field         <= 2'h0;
			clock_out_pin_full_rate_sel        <= 1'b0;
		end else begin
			if (wr_clk && i_addr == `CSO_ADDR_CTRL0) begin
				clock_out_pin_select_field  <= i_wdata[`CSO_C0_SEL_HI:`CSO_C0_SEL_LO];
				clock_out_pin_full_rate_sel <= i_wdata[`CSO_C0_FULL_RATE];
				if (guard_ok) begin
					o_ctrl.wait_f1_gate         <= i_wdata[`CSO_C0_WAIT_F1];
					o_ctrl.main_osc_stop        <= i_wdata[`CSO_C0_MAIN_STOP];
					o_ctrl.sub_clock_cpu_select <= i_wdata[`CSO_C0_SUB_CPU];
				end
			end
			if (wr_clk && i_addr == `CSO_ADDR_CTRL1) begin
				o_ctrl.slow_osc_off <= i_wdata[`CSO_C1_SLOW_OFF];
				if (guard_ok) begin
					o_ctrl.stop_mode_entry <= i_wdata[`CSO_C1_STOP_MODE];
					o_ctrl.pll_cpu_select  <= i_wdata[`CSO_C1_PLL_CPU];
				end
			end
			if (wr_clk && i_addr == `CSO_ADDR_CTRL2) begin
				o_ctrl.onchip_source_select   <= i_wdata[`CSO_C2_ONCHIP];
				o_ctrl.stop_detect_action_sel <= i_wdata[`CSO_C2_ACTION];
				if (guard_ok) begin
					o_ctrl.stop_detect_enable <= i_wdata[`CSO_C2_DET_EN];
				end
			end
			if (wr_ok && i_addr == `CSO_ADDR_CTRL2 && !i_wdata[`CSO_C2_FLAG]) begin
				o_ctrl.stop_detect_flag <= 1'b0;
			end
			if (wr_clk && guard_ok && i_addr == `CSO_ADDR_PLL) begin
				o_pll_config_reg <= i_wdata;
			end
			if (irq_evt) begin
				o_ctrl.stop_detect_flag <= 1'b1;
				o_ctrl.slow_osc_off     <= 1'b0;
				if (stop_evt) begin
					o_ctrl.main_osc_state <= 1'b1;
					if (!pll_mode) begin
						o_ctrl.onchip_source_select <= 1'b1;
					end
				end else begin
					o_ctrl.main_osc_state <= 1'b0;
				end
			end
			if (o_ctrl.onchip_source_select || (wr_clk && i_addr == `CSO_ADDR_CTRL2 && i_wdata[`CSO_C2_ONCHIP])) begin
				o_ctrl.slow_osc_off <= 1'b0;
			end
		end
	end

	// Non-maskable interrupt on the vector shared with the watchdog.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_nmi <= 1'b0;
		end else begin
			o_nmi <= irq_evt || i_wdt_irq;
		end
	end

	// Clock source selection for the CPU and the peripheral functions.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_cpu_src    <= CSO_SRC_ONCHIP;
			o_periph_src <= CSO_SRC_ONCHIP;
		end else begin
			if (o_ctrl.sub_clock_cpu_select) begin
				o_cpu_src <= CSO_SRC_SUB;
			end else if (o_ctrl.onchip_source_select) begin
				o_cpu_src <= CSO_SRC_ONCHIP;
			end else if (o_ctrl.pll_cpu_select) begin
				o_cpu_src <= CSO_SRC_PLL;
			end else begin
				o_cpu_src <= CSO_SRC_MAIN;
			end
			if (o_ctrl.onchip_source_select) begin
				o_periph_src <= CSO_SRC_ONCHIP;
			end else if (o_ctrl.pll_cpu_select) begin
				o_periph_src <= CSO_SRC_PLL;
			end else begin
				o_periph_src <= CSO_SRC_MAIN;
			end
		end
	end

	// Clock output selection.
	always_comb begin
		sel_tick  = 1'b0;
		sel_valid = 1'b1;
		case ({clock_out_pin_full_rate_sel, clock_out_pin_select_field})
			3'h4:    sel_tick = i_f1_tick;
			3'h2:    sel_tick = tick_div8;
			3'h3:    sel_tick = tick_div32;
			3'h1:    sel_tick = i_sub_tick;
			default: sel_valid = 1'b0;
		endcase
	end

	// Clock output pin toggles once per selected half-period tick and rests low when nothing is selected.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_clock_out_pin <= 1'b0;
		end else if (!sel_valid) begin
			o_clock_out_pin <= 1'b0;
		end else if (sel_tick) begin
			o_clock_out_pin <= !o_clock_out_pin;
		end
	end

	// Read data stands in the cycle after the read strobe and is zero otherwise.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= 8'h00;
			if (i_rd) begin
				case (i_addr)
					`CSO_ADDR_CTRL0: begin
						o_rdata[`CSO_C0_SEL_HI:`CSO_C0_SEL_LO] <= clock_out_pin_select_field;
						o_rdata[`CSO_C0_WAIT_F1]   <= o_ctrl.wait_f1_gate;
						o_rdata[`CSO_C0_MAIN_STOP] <= o_ctrl.main_osc_stop;
						o_rdata[`CSO_C0_SUB_CPU]   <= o_ctrl.sub_clock_cpu_select;
						o_rdata[`CSO_C0_FULL_RATE] <= clock_out_pin_full_rate_sel;
					end
					`CSO_ADDR_CTRL1: begin
						o_rdata[`CSO_C1_STOP_MODE] <= o_ctrl.stop_mode_entry;
						o_rdata[`CSO_C1_PLL_CPU]   <= o_ctrl.pll_cpu_select;
						o_rdata[`CSO_C1_SLOW_OFF]  <= o_ctrl.slow_osc_off;
					end
					`CSO_ADDR_CTRL2: begin
						o_rdata[`CSO_C2_DET_EN]    <= o_ctrl.stop_detect_enable;
						o_rdata[`CSO_C2_ONCHIP]    <= o_ctrl.onchip_source_select;
						o_rdata[`CSO_C2_FLAG]      <= o_ctrl.stop_detect_flag;
						o_rdata[`CSO_C2_OSC_STATE] <= o_ctrl.main_osc_state;
						o_rdata[`CSO_C2_ACTION]    <= o_ctrl.stop_detect_action_sel;
					end
					`CSO_ADDR_PROTECT: begin
						o_rdata[`CSO_PR_CLK_UNLOCK] <= clock_reg_write_unlock;
						o_rdata[`CSO_PR_PWR_UNLOCK] <= power_reg_write_unlock;
					end
					`CSO_ADDR_POWER: begin
						o_rdata[`CSO_PW_LOCK] <= o_clock_change_lock;
					end
					`CSO_ADDR_PLL: begin
						o_rdata <= o_pll_config_reg;
					end
					default: begin
						o_rdata <= 8'h00;
					end
				endcase
			end
		end
	end

endmodule // cso_clock_supervisor

`default_nettype wire

// ===== logic/cso_defs.svh
/*
 Register offsets, field positions, reset values and divider counts of the clock supervisor.
 Assumes an 8-bit register port with a 3-bit byte address.
*/
`ifndef CSO_DEFS_SVH
`define CSO_DEFS_SVH

`define CSO_ADDR_CTRL0      3'h0
`define CSO_ADDR_CTRL1      3'h1
`define CSO_ADDR_CTRL2      3'h2
`define CSO_ADDR_PROTECT    3'h3
`define CSO_ADDR_POWER      3'h4
`define CSO_ADDR_PLL        3'h5

`define CSO_C0_SEL_LO       0
`define CSO_C0_SEL_HI       1
`define CSO_C0_WAIT_F1      2
`define CSO_C0_MAIN_STOP    3
`define CSO_C0_SUB_CPU      4
`define CSO_C0_FULL_RATE    5
`define CSO_C1_STOP_MODE    0
`define CSO_C1_PLL_CPU      1
`define CSO_C1_SLOW_OFF     2
`define CSO_C2_DET_EN       0
`define CSO_C2_ONCHIP       1
`define CSO_C2_FLAG         2
`define CSO_C2_OSC_STATE    3
`define CSO_C2_ACTION       4
`define CSO_PR_CLK_UNLOCK   0
`define CSO_PR_PWR_UNLOCK   1
`define CSO_PW_LOCK         0

`define CSO_RST_ONCHIP      1'b1
`define CSO_RST_PLL         8'h00

`define CSO_DIV8            8
`define CSO_DIV32           32

`endif

// ===== logic/cso_pkg.sv
/*
 Types of the clock supervisor: clock source codes, detector states and the control bundle.
 Assumes nothing of its surroundings.
*/
package cso_pkg;

	typedef enum logic [1:0] {
		CSO_SRC_MAIN   = 2'b00,
		CSO_SRC_PLL    = 2'b01,
		CSO_SRC_ONCHIP = 2'b11,
		CSO_SRC_SUB    = 2'b10
	} cso_clk_src_t;

	typedef enum logic {
		CSO_DET_RUN  = 1'b0,
		CSO_DET_HOLD = 1'b1
	} cso_det_state_t;

	typedef struct packed {
		logic wait_f1_gate;
		logic main_osc_stop;
		logic sub_clock_cpu_select;
		logic stop_mode_entry;
		logic pll_cpu_select;
		logic slow_osc_off;
		logic stop_detect_enable;
		logic onchip_source_select;
		logic stop_detect_flag;
		logic main_osc_state;
		logic stop_detect_action_sel;
	} cso_ctrl_t;

endpackage

// ===== logic/cso_sync.sv
/*
 Two-flop synchroniser for asynchronous levels.
 Assumes the inputs are levels that stay stable for several clock periods.
*/
`timescale 1ns/100ps
`default_nettype none

module cso_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input  wire logic         i_clk,
	input  wire logic         i_resetn,
	// Levels.
	input  wire logic [W-1:0] i_async,
	output var  logic [W-1:0] o_sync
);

	logic [W-1:0] meta;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta   <= '0;
			o_sync <= '0;
		end else begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end

endmodule // cso_sync

`default_nettype wire

// ===== logic/cso_tick_div.sv
/*
 Divides a stream of tick pulses by a fixed count.
 Assumes input ticks are one-cycle pulses of the system clock.
*/
`timescale 1ns/100ps
`default_nettype none

module cso_tick_div #(
	parameter int DIV = 8
) (
	// Clock and reset.
	input  wire logic i_clk,
	input  wire logic i_resetn,
	// Ticks.
	input  wire logic i_tick,
	output var  logic o_tick
);

	localparam int W = $clog2(DIV);

	logic [W-1:0] count;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			count  <= '0;
			o_tick <= 1'b0;
		end else begin
			o_tick <= 1'b0;
			if (i_tick) begin
				if (count == W'(DIV - 1)) begin
					count  <= '0;
					o_tick <= 1'b1;
				end else begin
					count <= count + W'(1);
				end
			end
		end
	end

endmodule // cso_tick_div

`default_nettype wire

// ===== tb/cso_clock_supervisor_sva.sv
/*
 Port checker of the clock supervisor: detector events, lock and stop-reset hold.
 Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none

`include "cso_defs.svh"

module cso_clock_supervisor_sva
	import cso_pkg::*;
(
	// Clock and reset.
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_vmon0_reset,
	// Inputs watched.
	input  wire logic [2:0] i_addr,
	input  wire logic       i_wr,
	input  wire logic       i_main_osc_stopped,
	input  wire logic       i_wdt_irq,
	// Outputs watched.
	input  wire cso_ctrl_t  o_ctrl,
	input  wire logic [7:0] o_pll_config_reg,
	input  wire logic       o_clock_change_lock,
	input  wire logic       o_nmi,
	input  wire logic       o_stop_reset
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	wdt_nmi_a: assert property (i_wdt_irq && !i_vmon0_reset && !o_stop_reset |=> o_nmi)
		else $error("watchdog request gave no nmi");
	flag_nmi_a: assert property ($rose(o_ctrl.stop_detect_flag) |-> o_nmi)
		else $error("flag set without nmi");
	flag_block_a: assert property (o_ctrl.stop_detect_flag && $past(o_ctrl.stop_detect_flag) |-> $stable(o_ctrl.main_osc_state))
		else $error("event taken while flag set");
	osc_on_a: assert property (o_ctrl.onchip_source_select |-> !o_ctrl.slow_osc_off)
		else $error("slow oscillator off with onchip select");
	stop_state_a: assert property ($rose(o_ctrl.main_osc_state) && !$past(o_ctrl.pll_cpu_select) |->
		o_ctrl.onchip_source_select && o_ctrl.stop_detect_flag && o_nmi) else $error("stop outcome wrong");
	restart_state_a: assert property ($fell(o_ctrl.main_osc_state) && !$past(i_vmon0_reset) && !o_stop_reset |->
		o_ctrl.stop_detect_flag && o_nmi && $stable(o_ctrl.onchip_source_select)) else $error("restart outcome wrong");
	sync_delay_a: assert property ($rose(o_ctrl.stop_detect_flag) |-> o_ctrl.main_osc_state == $past(i_main_osc_stopped)
		&& $past(i_main_osc_stopped) == $past(i_main_osc_stopped, 2)) else $error("detector not synchronised");
	hold_keep_a: assert property (o_stop_reset && !i_vmon0_reset |=> o_stop_reset)
		else $error("stop reset hold released");
	hold_init_a: assert property ($rose(o_stop_reset) |-> o_ctrl.onchip_source_select && !o_ctrl.stop_detect_enable
		&& !o_clock_change_lock && o_pll_config_reg == 8'h00) else $error("hold without init");
	hold_cause_a: assert property ($rose(o_stop_reset) |-> $past(o_ctrl.stop_detect_enable)
		&& !$past(o_ctrl.stop_detect_action_sel)) else $error("hold without reset action");
	lock_pll_a: assert property (o_clock_change_lock && i_wr && i_addr == `CSO_ADDR_PLL && !i_vmon0_reset
		|=> $stable(o_pll_config_reg)) else $error("locked pll written");
endmodule // cso_clock_supervisor_sva

bind cso_clock_supervisor cso_clock_supervisor_sva cso_clock_supervisor_sva_i (.i_clk, .i_resetn, .i_vmon0_reset,
	.i_addr, .i_wr, .i_main_osc_stopped, .i_wdt_irq, .o_ctrl, .o_pll_config_reg, .o_clock_change_lock, .o_nmi,
	.o_stop_reset);

`default_nettype wire

// ===== tb/cso_pin_monitor.sv
/*
 Board-side monitor of the clock output pin: measures the half period in system clock cycles.
 Assumes the pin is a registered output of the system clock domain.
*/
`timescale 1ns/100ps
`default_nettype none

module cso_pin_monitor (
	// Clock and pin.
	input  wire logic i_clk,
	input  wire logic i_pin,
	// Measurement.
	output var  logic o_edge,
	output var  int   o_half
);
	logic last;
	int   cnt = 0;

	// Each pin change reports the cycles since the previous change.
	always_ff @(posedge i_clk) begin
		last <= i_pin;
		o_edge <= i_pin !== last;
		cnt <= (i_pin !== last) ? 1 : cnt + 1;
		o_half <= (i_pin !== last) ? cnt : o_half;
	end
endmodule // cso_pin_monitor

`default_nettype wire

// ===== tb/tb.sv
/*
 Self-checking testbench of the clock supervisor.
 Assumes a 40 MHz clock, register reads checked from a queue and the pin monitor as partner.
*/
`timescale 1ns/100ps
`default_nettype none

`include "cso_defs.svh"

module tb;
	import cso_pkg::*;
	logic         i_clk = 0, i_resetn = 0, i_vmon0_reset = 0, i_wr = 0, i_rd = 0;
	logic         i_f1_tick = 0, i_sub_tick = 0, i_main_osc_stopped = 0, i_wdt_irq = 0;
	logic [2:0]   i_addr = 0;
	logic [7:0]   i_wdata = 0, o_rdata, o_pll_config_reg, v;
	cso_ctrl_t    o_ctrl;
	cso_clk_src_t o_cpu_src, o_periph_src;
	logic         o_clock_change_lock, o_clock_out_pin, o_nmi, o_stop_reset, pin_edge, rd_seen = 0;
	int           pin_half, n_fail = 0, tests_run = 0, cyc = 0;
	logic [7:0]   rq [$];
	int           pq [$];
	logic [7:0]   sel [4] = '{8'h20, 8'h02, 8'h03, 8'h01};
	int           hp [4] = '{2, 16, 64, 5};

	cso_clock_supervisor cso_clock_supervisor_i (.i_clk, .i_resetn, .i_vmon0_reset, .i_addr, .i_wdata, .i_wr,
		.i_rd, .o_rdata, .i_f1_tick, .i_sub_tick, .i_main_osc_stopped, .i_wdt_irq, .o_ctrl, .o_pll_config_reg,
		.o_clock_change_lock, .o_cpu_src, .o_periph_src, .o_clock_out_pin, .o_nmi, .o_stop_reset);
	cso_pin_monitor cso_pin_monitor_i (.i_clk, .i_pin(o_clock_out_pin), .o_edge(pin_edge), .o_half(pin_half));

	initial begin
		forever #12.5 i_clk = ~i_clk;
	end

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk_n(input string n, input int e, input int g);
		tests_run++;
		if (g != e) begin
			n_fail++;
			$display("MISMATCH %s expected %0d seen %0d", n, e, g);
		end
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Tick sources, timeout and the monitor of read data and pin periods.
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		i_f1_tick <= (cyc % 2) == 0;
		i_sub_tick <= (cyc % 5) == 0;
		rd_seen <= i_rd;
		if (rd_seen)
			chk("read data", rq.pop_front(), o_rdata);
		if (pin_edge && pq.size() > 0)
			chk_n("pin half period", pq.pop_front(), pin_half);
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		rq.push_back(e);
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask

	task automatic det(input logic x);
		@(posedge i_clk);
		i_main_osc_stopped <= x;
		repeat (8) @(posedge i_clk);
	endtask

	initial begin
		void'($urandom(64203));
		repeat (3) @(posedge i_clk);
		i_resetn <= 1'b1;
		rd(`CSO_ADDR_CTRL2, 8'h02);
		rd(3'h7, 8'h00);
		wr(`CSO_ADDR_CTRL0, 8'h20);
		rd(`CSO_ADDR_CTRL0, 8'h00);
		chk("pin idle", 8'h00, {7'h00, o_clock_out_pin});
		wr(`CSO_ADDR_PROTECT, 8'h03);
		$display("test reset_protect done");
		for (int k = 0; k < 4; k++) begin
			wr(`CSO_ADDR_CTRL0, sel[k]);
			repeat (200) @(posedge i_clk);
			pq.push_back(hp[k]);
			repeat (80) @(posedge i_clk);
		end
		chk_n("pin checks left", 0, pq.size());
		$display("test clock_out done");
		v = 8'($urandom());
		wr(`CSO_ADDR_PLL, v);
		wr(`CSO_ADDR_POWER, 8'h01);
		rd(`CSO_ADDR_POWER, 8'h01);
		wr(`CSO_ADDR_PLL, ~v);
		rd(`CSO_ADDR_PLL, v);
		wr(`CSO_ADDR_CTRL1, 8'h03);
		rd(`CSO_ADDR_CTRL1, 8'h00);
		wr(`CSO_ADDR_CTRL2, 8'h03);
		rd(`CSO_ADDR_CTRL2, 8'h02);
		wr(`CSO_ADDR_CTRL0, 8'h1D);
		rd(`CSO_ADDR_CTRL0, 8'h01);
		wr(`CSO_ADDR_POWER, 8'h00);
		$display("test lock done");
		wr(`CSO_ADDR_CTRL2, 8'h11);
		wr(`CSO_ADDR_CTRL1, 8'h04);
		det(1'b1);
		rd(`CSO_ADDR_CTRL2, 8'h1F);
		rd(`CSO_ADDR_CTRL1, 8'h00);
		wr(`CSO_ADDR_CTRL2, 8'h1B);
		det(1'b0);
		rd(`CSO_ADDR_CTRL2, 8'h17);
		det(1'b1);
		rd(`CSO_ADDR_CTRL2, 8'h17);
		det(1'b0);
		wr(`CSO_ADDR_CTRL2, 8'h11);
		wr(`CSO_ADDR_CTRL1, 8'h02);
		det(1'b1);
		rd(`CSO_ADDR_CTRL2, 8'h1D);
		det(1'b0);
		wr(`CSO_ADDR_CTRL2, 8'h11);
		wr(`CSO_ADDR_CTRL1, 8'h00);
		wr(`CSO_ADDR_CTRL0, 8'h11);
		det(1'b1);
		chk("cpu source", {6'h00, CSO_SRC_SUB}, {6'h00, o_cpu_src});
		chk("peripheral source", {6'h00, CSO_SRC_ONCHIP}, {6'h00, o_periph_src});
		@(posedge i_clk);
		i_wdt_irq <= 1'b1;
		@(posedge i_clk);
		i_wdt_irq <= 1'b0;
		#1;
		chk("nmi", 8'h01, {7'h00, o_nmi});
		$display("test detector done");
		wr(`CSO_ADDR_CTRL2, 8'h12);
		det(1'b0);
		wr(`CSO_ADDR_CTRL2, 8'h03);
		det(1'b1);
		chk("stop reset", 8'h01, {7'h00, o_stop_reset});
		rd(`CSO_ADDR_CTRL2, 8'h02);
		wr(`CSO_ADDR_PROTECT, 8'h03);
		rd(`CSO_ADDR_PROTECT, 8'h00);
		chk("stop reset held", 8'h01, {7'h00, o_stop_reset});
		@(posedge i_clk);
		i_vmon0_reset <= 1'b1;
		@(posedge i_clk);
		i_vmon0_reset <= 1'b0;
		@(posedge i_clk);
		chk("stop reset released", 8'h00, {7'h00, o_stop_reset});
		$display("test stop_reset done");
		results();
	end
endmodule // tb

`default_nettype wire
